// File: design/data_move_indirect_exec.sv
// Execution unit for indirect, literal and work-to-file data moves
`include "data_move_cfg.svh"

module data_move_indirect_exec
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic instr_valid,
	output logic instr_ready,
	input data_move_pkg::instr_s instr,
	output data_move_pkg::mem_req_s mem_req,
	input wire logic [7:0] mem_rdata,
	output logic [7:0] work_reg,
	output logic [4:0] bank_select_reg,
	output logic [6:0] pc_upper_latch,
	output logic [15:0] file_pointer0,
	output logic [15:0] file_pointer1,
	output logic zero_flag,
	output logic busy
);
	import data_move_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Decode and address calculation

	exec_state_e state;
	exec_state_e next_state;
	logic accept;

	// Pointer arithmetic and addressing
	logic [15:0] sel_pointer;
	logic [15:0] ptr_plus;
	logic [15:0] ptr_minus;
	logic [15:0] ptr_offset;
	logic [15:0] indirect_addr;
	logic [15:0] next_pointer;
	logic [15:0] file_addr_full;
	logic file_is_indirect;
	logic file_pointer_sel;

	// Pointer registers and load completion
	logic pointer_step;
	logic load_done;
	logic [15:0] pointer [2];

	assign instr_ready = state == ST_IDLE;
	assign busy = state != ST_IDLE;
	assign accept = ce && instr_valid && instr_ready;

	// Both update forms share one adder pair; relative form only moves the address
	assign sel_pointer = pointer[instr.pointer_sel];
	// Sixteen-bit arithmetic wraps naturally at both ends
	assign ptr_plus = sel_pointer + 16'h0001;
	assign ptr_minus = sel_pointer - 16'h0001;
	assign ptr_offset = sel_pointer + {{10{instr.offset[5]}}, instr.offset};

	always_comb
	begin
		indirect_addr = sel_pointer;
		next_pointer = sel_pointer;
		// Relative form addresses pointer plus offset and keeps the pointer
		if (instr.relative)
		begin
			indirect_addr = ptr_offset;
			next_pointer = sel_pointer;
		end
		else
		begin
			case (instr.pointer_update_mode)
				`MODE_PRE_INC:
				begin
					indirect_addr = ptr_plus;
					next_pointer = ptr_plus;
				end
				`MODE_PRE_DEC:
				begin
					indirect_addr = ptr_minus;
					next_pointer = ptr_minus;
				end
				// Post forms address the old value and step it afterwards
				`MODE_POST_INC:
				begin
					indirect_addr = sel_pointer;
					next_pointer = ptr_plus;
				end
				`MODE_POST_DEC:
				begin
					indirect_addr = sel_pointer;
					next_pointer = ptr_minus;
				end
				default:
				begin
					indirect_addr = sel_pointer;
					next_pointer = sel_pointer;
				end
			endcase
		end
	end

	// File addresses of the indirect locations are redirected through a pointer
	assign file_is_indirect = instr.file_addr == `INDIRECT0_FILE_ADDR
		|| instr.file_addr == `INDIRECT1_FILE_ADDR;
	assign file_pointer_sel = instr.file_addr == `INDIRECT1_FILE_ADDR;

	// Direct addresses are paged by the bank-select register
	always_comb
	begin
		file_addr_full = {4'h0, bank_select_reg, instr.file_addr};
		if (file_is_indirect)
		begin
			file_addr_full = file_pointer_sel ? file_pointer1 : file_pointer0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencing of indirect loads

	// The read leaves one cycle after intake and its data is back one cycle later
	assign load_done = state == ST_READ_DATA;

	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
			begin
				if (accept && instr.opcode == OP_INDIRECT_LOAD)
				begin
					next_state = ST_READ_REQ;
				end
			end
			ST_READ_REQ:
			begin
				next_state = ST_READ_DATA;
			end
			ST_READ_DATA:
			begin
				next_state = ST_IDLE;
			end
			// An illegal code falls back to idle
			default:
			begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state <= ST_IDLE;
		end
		// Clock enable low freezes the sequence where it stands
		else if (ce)
		begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Memory request

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			mem_req.addr <= `MEM_ADDR_RESET;
			mem_req.wdata <= `MEM_DATA_RESET;
			mem_req.read <= 1'b0;
			mem_req.write <= 1'b0;
		end
		else if (ce)
		begin
			// Pulses stand one enabled cycle; a low clock enable stretches them
			mem_req.read <= 1'b0;
			mem_req.write <= 1'b0;
			if (accept)
			begin
				case (instr.opcode)
					OP_INDIRECT_LOAD:
					begin
						mem_req.addr <= indirect_addr;
						mem_req.read <= 1'b1;
					end
					OP_INDIRECT_STORE:
					begin
						mem_req.addr <= indirect_addr;
						mem_req.wdata <= work_reg;
						mem_req.write <= 1'b1;
					end
					OP_WORK_TO_FILE:
					begin
						mem_req.addr <= file_addr_full;
						mem_req.wdata <= work_reg;
						mem_req.write <= 1'b1;
					end
					// Literal moves and the idle code keep the request address and data; read and write drop to 0
					default:
					begin
						mem_req.addr <= mem_req.addr;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// File pointers: only the selected one steps, and only on an indirect move

	assign pointer_step = accept
		&& (instr.opcode == OP_INDIRECT_LOAD || instr.opcode == OP_INDIRECT_STORE);

	// One register per pointer, each stepping only when it is the one selected
	generate
		for (genvar g = 0; g < 2; g++)
		begin : gen_pointer
			always_ff @(posedge ref_clk or posedge rst)
			begin
				if (rst)
				begin
					pointer[g] <= `POINTER_RESET;
				end
				else if (pointer_step && instr.pointer_sel == 1'(g))
				begin
					pointer[g] <= next_pointer;
				end
			end
		end
	endgenerate

	// No status flag is written here, so a pointer step leaves them as they were
	assign file_pointer0 = pointer[0];
	assign file_pointer1 = pointer[1];

	////////////////////////////////////////////////////////////////////////////
	// Working register

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			work_reg <= `WORK_RESET;
		end
		else if (ce)
		begin
			// Intake is closed while a load runs, so the two writes never meet
			if (accept && instr.opcode == OP_WORK_LITERAL)
			begin
				work_reg <= instr.literal;
			end
			else if (load_done)
			begin
				work_reg <= mem_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bank select and program latch

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			bank_select_reg <= `BANK_RESET;
		end
		else if (ce && accept && instr.opcode == OP_BANK_LITERAL)
		begin
			// Five bits are kept; the upper literal bits are dropped
			bank_select_reg <= instr.literal[4:0];
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pc_upper_latch <= `LATCH_RESET;
		end
		else if (ce && accept && instr.opcode == OP_PC_LATCH_LITERAL)
		begin
			pc_upper_latch <= instr.literal[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Zero flag: only an indirect load changes it

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			zero_flag <= `ZERO_RESET;
		end
		else if (ce && load_done)
		begin
			// Same byte that lands in the working register at this edge
			zero_flag <= mem_rdata == 8'h00;
		end
	end

endmodule

// File: design/data_move_cfg.svh
// Constants for the data-move execution block
// Overview of operation
// - Indirect load/store move data via pointer address
// - Mode 00 pre-inc,01 pre-dec,10 post-inc,11 post-dec
// - Address: pointer +1, -1 (pre), pointer (post), or signed offset
// - Pointer after: +1 inc, -1 dec, relative unchanged
// - Sixteen-bit pointer wraps modulo full range
// - Pointer update leaves status flags alone
// - Indirect location accesses pointer-addressed register instead
// - Bank literal loads bank register, flags untouched
// - Seven-bit literal loads program latch, flags untouched
// - Eight-bit literal loads work register, one cycle
// - Work register stored to file, one cycle
`ifndef DATA_MOVE_CFG_SVH
`define DATA_MOVE_CFG_SVH

`define MODE_PRE_INC 2'h0
`define MODE_PRE_DEC 2'h1
`define MODE_POST_INC 2'h2
`define MODE_POST_DEC 2'h3
`define MODE_POST_BIT 1
`define MODE_DEC_BIT 0

`define INDIRECT0_FILE_ADDR 7'h00
`define INDIRECT1_FILE_ADDR 7'h01

`define WORK_RESET 8'h00
`define BANK_RESET 5'h00
`define LATCH_RESET 7'h00
`define POINTER_RESET 16'h0000
`define MEM_ADDR_RESET 16'h0000
`define MEM_DATA_RESET 8'h00
`define ZERO_RESET 1'h0

`endif

// File: design/data_move_pkg.sv
// Types shared by the data-move execution block
package data_move_pkg;

	typedef enum logic [2:0]
	{
		OP_NONE = 3'h0,
		OP_INDIRECT_LOAD = 3'h1,
		OP_INDIRECT_STORE = 3'h2,
		OP_BANK_LITERAL = 3'h3,
		OP_PC_LATCH_LITERAL = 3'h4,
		OP_WORK_LITERAL = 3'h5,
		OP_WORK_TO_FILE = 3'h6
	} opcode_e;

	typedef struct packed
	{
		opcode_e opcode;
		logic pointer_sel;
		logic relative;
		logic [1:0] pointer_update_mode;
		logic [5:0] offset;
		logic [7:0] literal;
		logic [6:0] file_addr;
	} instr_s;

	typedef struct packed
	{
		logic [15:0] addr;
		logic [7:0] wdata;
		logic read;
		logic write;
	} mem_req_s;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'h1,
		ST_READ_REQ = 3'h2,
		ST_READ_DATA = 3'h4
	} exec_state_e;

endpackage

// File: test/dm_props.sv
// Assertion checker for the data-move execution block
module dm_props
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input data_move_pkg::instr_s instr,
	input data_move_pkg::mem_req_s mem_req,
	input wire logic [7:0] mem_rdata,
	input wire logic [7:0] work_reg,
	input wire logic [4:0] bank_select_reg,
	input wire logic [6:0] pc_upper_latch,
	input wire logic [15:0] file_pointer0,
	input wire logic [15:0] file_pointer1,
	input wire logic zero_flag,
	input wire logic busy
);
timeunit 1ns;
timeprecision 1ns;
import data_move_pkg::*;
default clocking
	@(posedge ref_clk);
endclocking
default disable iff (rst);
logic t;
logic ind;
opcode_e o;
logic [15:0] p, n, e;
assign o = instr.opcode;
assign t = ce & instr_valid & instr_ready;
assign ind = t && (o == OP_INDIRECT_LOAD || o == OP_INDIRECT_STORE);
// Expected address and pointer for the offered indirect move
always_comb
begin
	p = instr.pointer_sel ? file_pointer1 : file_pointer0;
	n = instr.pointer_update_mode[0] ? p - 16'h0001 : p + 16'h0001;
	e = instr.pointer_update_mode[1] ? p : n;
	if (instr.relative)
	begin
		n = p;
		e = p + {{10{instr.offset[5]}}, instr.offset};
	end
end
addr_calc_a: assert property (ind |=> mem_req.addr == $past(e))
	else $error("bad address");
ptr_step_a: assert property (ind |=>
	($past(instr.pointer_sel) ? file_pointer1 : file_pointer0) == $past(n))
	else $error("bad pointer");
load_walk_a: assert property (t && o == OP_INDIRECT_LOAD |=> mem_req.read && busy
	##1 busy ##1 !busy && work_reg == $past(mem_rdata) && zero_flag == (work_reg == 8'h00))
	else $error("bad load");
store_data_a: assert property (t && o == OP_INDIRECT_STORE |=>
	mem_req.write && mem_req.wdata == $past(work_reg))
	else $error("bad store");
file_store_a: assert property (t && o == OP_WORK_TO_FILE && instr.file_addr > 7'h01 |=>
	mem_req.write && mem_req.addr == {4'h0, $past(bank_select_reg), $past(instr.file_addr)})
	else $error("bad file store");
bank_load_a: assert property (t && o == OP_BANK_LITERAL |=>
	bank_select_reg == $past(instr.literal[4:0]))
	else $error("bad bank");
latch_load_a: assert property (t && o == OP_PC_LATCH_LITERAL |=>
	pc_upper_latch == $past(instr.literal[6:0]))
	else $error("bad latch");
work_load_a: assert property (t && o == OP_WORK_LITERAL |=> work_reg == $past(instr.literal))
	else $error("bad literal");
flag_hold_a: assert property (t && o != OP_INDIRECT_LOAD |=> $stable(zero_flag))
	else $error("flag moved");
cover property (t && o == OP_INDIRECT_LOAD && instr.relative);
cover property (ind && p == 16'hFFFF);
cover property (t && o == OP_WORK_TO_FILE && instr.file_addr < 7'h02);
endmodule
bind data_move_indirect_exec dm_props props (.*);

// File: test/tb_data_move_indirect_exec.sv
// Random and corner bench for the data-move execution block
module tb_data_move_indirect_exec;
timeunit 1ns;
timeprecision 1ns;
import data_move_pkg::*;
logic ref_clk = 0, rst = 1, ce = 1, instr_valid = 0, instr_ready, busy, zero_flag, z = 0;
logic [7:0] mem_rdata = 8'h00, work_reg, w = 8'h00;
logic [4:0] bank_select_reg, bank = 5'h00;
logic [6:0] pc_upper_latch, latch = 7'h00;
logic [15:0] file_pointer0, file_pointer1, p, n, e, fp [2] = '{16'h0000, 16'h0000};
int seed = 32'h7B9C, miscompares = 0, total_checks = 0, k, r;
instr_s instr = '0, i;
mem_req_s mem_req;
data_move_indirect_exec dut (.*);
initial
	forever #20 ref_clk = ~ref_clk;
always @(posedge ref_clk)
	if (mem_req.read)
		mem_rdata <= mem_req.addr[7:0] ^ mem_req.addr[15:8];
task chk(input logic [15:0] s, input logic [15:0] x);
	total_checks++;
	if (s !== x)
	begin
		miscompares++;
		$display("unexpected at %0t: saw %h want %h", $time, s, x);
	end
endtask
task conclude;
	$display("checks %0d miscompares %0d", total_checks, miscompares);
	if (miscompares == 0 && total_checks > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
endtask
function instr_s mk(opcode_e o, logic s, logic r, logic [1:0] m, logic [5:0] f, logic [7:0] l);
	mk = {o, s, r, m, f, l, l[6:0]};
endfunction
// Valid stays up between instructions so the next one is offered at once
task run(input instr_s a);
	instr = a;
	instr_valid = 1;
	@(posedge ref_clk);
	#1;
	p = fp[a.pointer_sel];
	n = a.pointer_update_mode[0] ? p - 16'h0001 : p + 16'h0001;
	e = a.pointer_update_mode[1] ? p : n;
	if (a.relative)
	begin
		n = p;
		e = p + {{10{a.offset[5]}}, a.offset};
	end
	case (a.opcode)
	OP_INDIRECT_LOAD, OP_INDIRECT_STORE:
	begin
		chk(mem_req.addr, e);
		chk({mem_req.read, mem_req.write}, a.opcode == OP_INDIRECT_LOAD ? 2'h2 : 2'h1);
		fp[a.pointer_sel] = n;
		if (a.opcode == OP_INDIRECT_STORE)
			chk(mem_req.wdata, w);
		else
		begin
			chk({instr_ready, busy}, 2'h1);
			repeat (2) @(posedge ref_clk);
			#1;
			chk(mem_req.read, 1'b0);
			w = e[7:0] ^ e[15:8];
			z = w == 8'h00;
		end
	end
	OP_BANK_LITERAL: bank = a.literal[4:0];
	OP_PC_LATCH_LITERAL: latch = a.literal[6:0];
	OP_WORK_LITERAL: w = a.literal;
	OP_WORK_TO_FILE:
	begin
		chk(mem_req.addr, a.file_addr < 2 ? fp[a.file_addr[0]] : {4'h0, bank, a.file_addr});
		chk({mem_req.write, mem_req.wdata}, {1'b1, w});
	end
	default: ;
	endcase
	chk(work_reg, w);
	chk(zero_flag, z);
	chk({bank_select_reg, pc_upper_latch}, {bank, latch});
	chk(file_pointer0, fp[0]);
	chk(file_pointer1, fp[1]);
	chk({instr_ready, busy}, 2'h2);
endtask
initial
begin
	repeat (2) @(posedge ref_clk);
	#1;
	rst = 0;
	run(mk(OP_INDIRECT_LOAD, 0, 0, 2'h1, 0, 0));
	run(mk(OP_INDIRECT_LOAD, 0, 0, 2'h0, 0, 0));
	run(mk(OP_WORK_LITERAL, 0, 0, 0, 0, 8'hA5));
	run(mk(OP_INDIRECT_LOAD, 1, 1, 0, 6'h20, 0));
	run(mk(OP_INDIRECT_STORE, 1, 1, 0, 6'h1F, 0));
	for (k = 0; k < 4; k++)
		run(mk(OP_INDIRECT_STORE, k[0], 0, k[1:0], 0, 0));
	for (k = 0; k < 2; k++)
		run(mk(OP_WORK_TO_FILE, 0, 0, 0, 0, k[7:0]));
	ce = 0;
	instr = mk(OP_WORK_LITERAL, 0, 0, 0, 0, 8'h3C);
	@(posedge ref_clk);
	#1;
	chk({mem_req.write, work_reg}, {1'b1, w});
	ce = 1;
	$display("corner test done");
	for (k = 0; k < 400; k++)
	begin
		r = $random(seed);
		i = instr_s'(r[27:0]);
		if (i.opcode == 3'h7)
			i.opcode = OP_WORK_LITERAL;
		run(i);
	end
	$display("random test done");
	conclude;
end
initial
begin
	#200000;
	miscompares++;
	conclude;
end
endmodule
